// file: ddrmr_pkg.sv
// constants, field layout and encodings of the mode and extended register block
// assumes a single 40 MHz clock and an AXI4-Lite register slave with 32-bit data
`default_nettype none
package ddrmr_pkg;
  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_MODE     = 8'h00;
  localparam logic [7:0] OFS_EXT1     = 8'h04;
  localparam logic [7:0] OFS_EXT2     = 8'h08;
  localparam logic [7:0] OFS_EXT3     = 8'h0C;
  localparam logic [7:0] OFS_STRENGTH = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;
  // ---------------------------------------------------------------
  // bank select targets
  // ---------------------------------------------------------------
  localparam logic [1:0] BANK_MODE = 2'h0;
  localparam logic [1:0] BANK_EXT1 = 2'h1;
  localparam logic [1:0] BANK_EXT2 = 2'h2;
  localparam logic [1:0] BANK_EXT3 = 2'h3;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int LEN_LSB  = 0;
  localparam int BT_BIT   = 3;
  localparam int RDL_LSB  = 4;
  localparam int TM_BIT   = 7;
  localparam int DLLR_BIT = 8;
  localparam int WR_LSB   = 9;
  localparam int DLLD_BIT = 0;
  localparam int RDS_BIT  = 1;
  localparam int RTT0_BIT = 2;
  localparam int ADL_LSB  = 3;
  localparam int RTT1_BIT = 6;
  localparam int CAL_LSB  = 7;
  localparam int NDQS_BIT = 10;
  localparam int ESR_BIT  = 7;
  // ---------------------------------------------------------------
  // encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] LEN_CODE4    = 3'h2;
  localparam logic [2:0] LEN_CODE8    = 3'h3;
  localparam logic [2:0] CAL_EXIT     = 3'h0;
  localparam logic [2:0] CAL_DRIVE_HI = 3'h1;
  localparam logic [2:0] CAL_DRIVE_LO = 3'h2;
  localparam logic [2:0] CAL_ADJUST   = 3'h4;
  localparam logic [2:0] CAL_DEFAULT  = 3'h7;
  localparam logic [3:0] STEP_RST     = 4'h8;
  localparam logic [3:0] STEP_MAX     = 4'hF;
  localparam logic [3:0] STEP_MIN     = 4'h0;
  localparam logic [12:0] REG_RST     = 13'h0000;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
endpackage : ddrmr_pkg
`default_nettype wire

// file: ddrmr_top.sv
// mode / extended register decode, dll control and driver impedance calibration
// assumes command pins synchronous to ref_clk_i, adjust beats given as rise/fall pairs
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`default_nettype none
module ddrmr_top #(
  parameter int DQ_W = 16
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              cs_n_i,
  input  wire logic              ras_n_i,
  input  wire logic              cas_n_i,
  input  wire logic              we_n_i,
  input  wire logic              cke_i,
  input  wire logic [1:0]        bank_select_i,
  input  wire logic [12:0]       addr_i,
  input  wire logic [DQ_W-1:0]   dq_rise_i,
  input  wire logic [DQ_W-1:0]   dq_fall_i,
  output logic [DQ_W-1:0]        dq_o,
  output logic                   dq_oe_n_o,
  output logic                   dqs_o,
  output logic                   dqs_n_o,
  output logic                   dqs_oe_n_o,
  output logic [2:0]             burst_length_o,
  output logic                   burst_type_o,
  output logic [2:0]             read_latency_setting_o,
  output logic                   test_mode_o,
  output logic                   dll_reset_o,
  output logic [2:0]             write_recovery_o,
  output logic                   dll_enable_o,
  output logic                   reduced_drive_o,
  output logic [2:0]             additive_latency_o,
  output logic [1:0]             termination_o,
  output logic                   strobe_n_disable_o,
  output logic [2:0]             calibration_mode_o,
  output logic                   extended_refresh_rate_o,
  output logic [3:0]             pull_up_step_o,
  output logic [3:0]             pull_down_step_o,
  output logic                   self_refresh_o,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ADJ_IDLE,
    ADJ_WAIT,
    ADJ_LATE,
    ADJ_APPLY
  } ddrmr_adj_t;

  typedef struct packed {
    logic [12:0]     mode_reg;
    logic [12:0]     ext1_reg;
    logic [12:0]     ext2_reg;
    logic [12:0]     ext3_reg;
    logic [3:0]      pu_step;
    logic [3:0]      pd_step;
    logic            in_sr;
    logic            dll_run;
    logic            dll_rst;
    ddrmr_adj_t      adj;
    logic [3:0]      cnt;
    logic [3:0]      code;
    logic [DQ_W-1:0] dq;
    logic            dq_oe_n;
    logic            dqs;
    logic            dqs_n;
    logic            awready;
    logic            wready;
    logic            aw_got;
    logic            w_got;
    logic [7:0]      awaddr;
    logic [31:0]     wdata;
    logic [3:0]      wstrb;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            arready;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
  } ddrmr_state_t;

  ddrmr_state_t s;
  ddrmr_state_t next_s;

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  logic reg_write;
  logic sr_entry;
  logic [2:0] new_cal;
  logic [3:0] wlat;

  // all four strobes low with clock gate high writes a register
  assign reg_write = ~cs_n_i & ~ras_n_i & ~cas_n_i & ~we_n_i & cke_i;
  assign sr_entry  = ~cs_n_i & ~ras_n_i & ~cas_n_i & we_n_i & ~cke_i;
  assign new_cal   = addr_i[ddrmr_pkg::CAL_LSB +: 3];
  // write latency is additive plus read latency minus one
  assign wlat = 4'({1'b0, s.ext1_reg[ddrmr_pkg::ADL_LSB +: 3]})
              + 4'({1'b0, s.mode_reg[ddrmr_pkg::RDL_LSB +: 3]}) - 4'h1;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [3:0] ddrmr_step(input logic [3:0] v, input logic inc, input logic dec);
    logic [3:0] r;
    r = v;
    if (inc && v != ddrmr_pkg::STEP_MAX) begin
      r = v + 4'h1;
    end else if (dec && v != ddrmr_pkg::STEP_MIN) begin
      r = v - 4'h1;
    end
    return r;
  endfunction : ddrmr_step

  function automatic logic [31:0] ddrmr_read(input ddrmr_state_t st, input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      ddrmr_pkg::OFS_MODE:     r = {19'h0_0000, st.mode_reg};
      ddrmr_pkg::OFS_EXT1:     r = {19'h0_0000, st.ext1_reg};
      ddrmr_pkg::OFS_EXT2:     r = {19'h0_0000, st.ext2_reg};
      ddrmr_pkg::OFS_EXT3:     r = {19'h0_0000, st.ext3_reg};
      ddrmr_pkg::OFS_STRENGTH: r = {24'h00_0000, st.pd_step, st.pu_step};
      ddrmr_pkg::OFS_STATUS:   r = {27'h000_0000, st.adj, st.dll_rst, st.dll_run, st.in_sr};
      default:                 r = 32'h0000_0000;
    endcase
    return r;
  endfunction : ddrmr_read

  function automatic logic ddrmr_mapped(input logic [7:0] a);
    return (a == ddrmr_pkg::OFS_MODE) || (a == ddrmr_pkg::OFS_EXT1) || (a == ddrmr_pkg::OFS_EXT2)
        || (a == ddrmr_pkg::OFS_EXT3) || (a == ddrmr_pkg::OFS_STRENGTH) || (a == ddrmr_pkg::OFS_STATUS);
  endfunction : ddrmr_mapped

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic pu_inc;
    logic pu_dec;
    logic pd_inc;
    logic pd_dec;
    logic [3:0] c;
    pu_inc = 1'b0;
    pu_dec = 1'b0;
    pd_inc = 1'b0;
    pd_dec = 1'b0;
    c      = s.code;
    next_s = s;
    next_s.dll_rst = 1'b0;

    // register programming
    if (reg_write) begin
      unique case (bank_select_i)
        ddrmr_pkg::BANK_MODE: begin
          next_s.mode_reg = addr_i;
          next_s.dll_rst  = addr_i[ddrmr_pkg::DLLR_BIT];
        end
        ddrmr_pkg::BANK_EXT1: begin
          next_s.ext1_reg = addr_i;
          if (new_cal == ddrmr_pkg::CAL_ADJUST) begin
            // previously programmed additive latency stays in force
            next_s.ext1_reg[ddrmr_pkg::ADL_LSB +: 3] = s.ext1_reg[ddrmr_pkg::ADL_LSB +: 3];
            next_s.adj = ADJ_WAIT;
            next_s.cnt = wlat - 4'h1;
          end
        end
        ddrmr_pkg::BANK_EXT2: begin
          next_s.ext2_reg = addr_i;
        end
        ddrmr_pkg::BANK_EXT3: begin
          next_s.ext3_reg = addr_i;
        end
      endcase
    end

    // self refresh turns the dll off, exit re-enables and resets it
    if (sr_entry) begin
      next_s.in_sr = 1'b1;
    end else if (s.in_sr && cke_i) begin
      next_s.in_sr   = 1'b0;
      next_s.dll_rst = 1'b1;
    end
    next_s.dll_run = ~next_s.ext1_reg[ddrmr_pkg::DLLD_BIT] & ~next_s.in_sr;

    // adjust data capture, beats in fixed order regardless of burst type
    unique case (s.adj)
      ADJ_IDLE: begin
      end
      ADJ_WAIT: begin
        if (s.cnt == 4'h0) begin
          next_s.code = {dq_rise_i[0], dq_fall_i[0], 2'b00};
          next_s.adj  = ADJ_LATE;
        end else begin
          next_s.cnt = s.cnt - 4'h1;
        end
      end
      ADJ_LATE: begin
        next_s.code = {s.code[3:2], dq_rise_i[0], dq_fall_i[0]};
        next_s.adj  = ADJ_APPLY;
      end
      ADJ_APPLY: begin
        next_s.adj = ADJ_IDLE;
        unique case (c)
          4'h1: pu_inc = 1'b1;
          4'h2: pu_dec = 1'b1;
          4'h4: pd_inc = 1'b1;
          4'h8: pd_dec = 1'b1;
          4'h5: begin
            pu_inc = 1'b1;
            pd_inc = 1'b1;
          end
          4'h6: begin
            pu_dec = 1'b1;
            pd_inc = 1'b1;
          end
          4'h9: begin
            pu_inc = 1'b1;
            pd_dec = 1'b1;
          end
          4'hA: begin
            pu_dec = 1'b1;
            pd_dec = 1'b1;
          end
          // no-op and reserved codes leave both strengths alone
          default: begin
            pu_inc = 1'b0;
          end
        endcase
      end
    endcase

    // software presets the step first, a pending adjustment then moves it
    if (s.aw_got && s.w_got && !s.bvalid && s.awaddr == ddrmr_pkg::OFS_STRENGTH && s.wstrb[0]) begin
      next_s.pu_step = s.wdata[3:0];
      next_s.pd_step = s.wdata[7:4];
    end
    // one step value for every data line and strobe
    next_s.pu_step = ddrmr_step(next_s.pu_step, pu_inc, pu_dec);
    next_s.pd_step = ddrmr_step(next_s.pd_step, pd_inc, pd_dec);

    // drive modes
    unique case (next_s.ext1_reg[ddrmr_pkg::CAL_LSB +: 3])
      ddrmr_pkg::CAL_DRIVE_HI: begin
        next_s.dq      = '1;
        next_s.dqs     = 1'b1;
        next_s.dqs_n   = 1'b0;
        next_s.dq_oe_n = 1'b0;
      end
      ddrmr_pkg::CAL_DRIVE_LO: begin
        next_s.dq      = '0;
        next_s.dqs     = 1'b0;
        next_s.dqs_n   = 1'b1;
        next_s.dq_oe_n = 1'b0;
      end
      // exit, adjust, default and unused codes leave the drivers off
      default: begin
        next_s.dq      = '0;
        next_s.dqs     = 1'b0;
        next_s.dqs_n   = 1'b0;
        next_s.dq_oe_n = 1'b1;
      end
    endcase

    // axi write channels, taken in either order
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = ddrmr_mapped(s.awaddr) ? ddrmr_pkg::RESP_OKAY : ddrmr_pkg::RESP_SLVERR;
    end else if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    next_s.awready = ~next_s.aw_got;
    next_s.wready  = ~next_s.w_got;

    // axi read channel
    if (s_axi_arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = ddrmr_read(s, s_axi_araddr);
      next_s.rresp  = ddrmr_mapped(s_axi_araddr) ? ddrmr_pkg::RESP_OKAY : ddrmr_pkg::RESP_SLVERR;
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    next_s.arready = ~next_s.rvalid;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s          <= '0;
      s.mode_reg <= ddrmr_pkg::REG_RST;
      s.ext1_reg <= ddrmr_pkg::REG_RST;
      s.pu_step  <= ddrmr_pkg::STEP_RST;
      s.pd_step  <= ddrmr_pkg::STEP_RST;
      s.adj      <= ADJ_IDLE;
      s.dq_oe_n  <= 1'b1;
      s.awready  <= 1'b1;
      s.wready   <= 1'b1;
      s.arready  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign dq_o                    = s.dq;
  assign dq_oe_n_o               = s.dq_oe_n;
  assign dqs_o                   = s.dqs;
  assign dqs_n_o                 = s.dqs_n;
  assign dqs_oe_n_o              = s.dq_oe_n;
  assign burst_length_o          = s.mode_reg[ddrmr_pkg::LEN_LSB +: 3];
  assign burst_type_o            = s.mode_reg[ddrmr_pkg::BT_BIT];
  assign read_latency_setting_o  = s.mode_reg[ddrmr_pkg::RDL_LSB +: 3];
  assign test_mode_o             = s.mode_reg[ddrmr_pkg::TM_BIT];
  assign dll_reset_o             = s.dll_rst;
  assign write_recovery_o        = s.mode_reg[ddrmr_pkg::WR_LSB +: 3];
  assign dll_enable_o            = s.dll_run;
  assign reduced_drive_o         = s.ext1_reg[ddrmr_pkg::RDS_BIT];
  assign additive_latency_o      = s.ext1_reg[ddrmr_pkg::ADL_LSB +: 3];
  assign termination_o           = {s.ext1_reg[ddrmr_pkg::RTT1_BIT], s.ext1_reg[ddrmr_pkg::RTT0_BIT]};
  assign strobe_n_disable_o      = s.ext1_reg[ddrmr_pkg::NDQS_BIT];
  assign calibration_mode_o      = s.ext1_reg[ddrmr_pkg::CAL_LSB +: 3];
  assign extended_refresh_rate_o = s.ext2_reg[ddrmr_pkg::ESR_BIT];
  assign pull_up_step_o          = s.pu_step;
  assign pull_down_step_o        = s.pd_step;
  assign self_refresh_o          = s.in_sr;
  assign s_axi_awready           = s.awready;
  assign s_axi_wready            = s.wready;
  assign s_axi_bresp             = s.bresp;
  assign s_axi_bvalid            = s.bvalid;
  assign s_axi_arready           = s.arready;
  assign s_axi_rdata             = s.rdata;
  assign s_axi_rresp             = s.rresp;
  assign s_axi_rvalid            = s.rvalid;

endmodule : ddrmr_top
`default_nettype wire

// file: ddrmr_chk.sv
// concurrent checks of the command pins, field outputs and driver levels
// assumes bind into ddrmr_top; one clock, asynchronous active-low reset
`default_nettype none
module ddrmr_chk #(
  parameter int DQ_W = 16
) (
  input wire logic            ref_clk_i,
  input wire logic            rst_n_i,
  input wire logic            cs_n_i,
  input wire logic            ras_n_i,
  input wire logic            cas_n_i,
  input wire logic            we_n_i,
  input wire logic            cke_i,
  input wire logic [1:0]      bank_select_i,
  input wire logic [12:0]     addr_i,
  input wire logic [DQ_W-1:0] dq_o,
  input wire logic            dq_oe_n_o,
  input wire logic            dqs_o,
  input wire logic            dqs_n_o,
  input wire logic            dqs_oe_n_o,
  input wire logic [2:0]      burst_length_o,
  input wire logic            burst_type_o,
  input wire logic [2:0]      read_latency_setting_o,
  input wire logic            test_mode_o,
  input wire logic            dll_reset_o,
  input wire logic [2:0]      write_recovery_o,
  input wire logic            dll_enable_o,
  input wire logic [2:0]      additive_latency_o,
  input wire logic            reduced_drive_o,
  input wire logic [1:0]      termination_o,
  input wire logic            strobe_n_disable_o,
  input wire logic [2:0]      calibration_mode_o,
  input wire logic            extended_refresh_rate_o,
  input wire logic            self_refresh_o
);
  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  logic wr;
  logic sre;
  assign wr  = !cs_n_i && !ras_n_i && !cas_n_i && !we_n_i && cke_i;
  assign sre = !cs_n_i && !ras_n_i && !cas_n_i && we_n_i && !cke_i;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_MODE_BL: assert property (wr && bank_select_i == 2'h0 |=> burst_length_o == $past(addr_i[2:0]))
    else $error("burst length differs from mode write");
  AST_MODE_LAT: assert property (wr && bank_select_i == 2'h0 |=>
    {write_recovery_o, test_mode_o, read_latency_setting_o, burst_type_o} ==
    {$past(addr_i[11:9]), $past(addr_i[7:3])})
    else $error("mode fields differ from mode write");
  AST_DLL_RST: assert property (wr && bank_select_i == 2'h0 && addr_i[8] |=> dll_reset_o)
    else $error("dll reset not raised");
  AST_EXT1: assert property (wr && bank_select_i == 2'h1 && addr_i[9:7] != 3'h4 |=>
    {strobe_n_disable_o, calibration_mode_o, termination_o[1], additive_latency_o, termination_o[0], reduced_drive_o}
      == $past(addr_i[10:1]))
    else $error("first extended fields differ");
  AST_ADJ_AL: assert property (wr && bank_select_i == 2'h1 && addr_i[9:7] == 3'h4 |=>
    $stable(additive_latency_o))
    else $error("additive latency changed by adjust");
  AST_EXT2: assert property (wr && bank_select_i == 2'h2 |=> extended_refresh_rate_o == $past(addr_i[7]))
    else $error("refresh rate bit differs");
  AST_DRV_HI: assert property (calibration_mode_o == 3'h1 |-> dq_o == '1 && dqs_o && !dqs_n_o && !dq_oe_n_o)
    else $error("drive high levels wrong");
  AST_DRV_LO: assert property (calibration_mode_o == 3'h2 |-> dq_o == '0 && !dqs_o && dqs_n_o && !dqs_oe_n_o)
    else $error("drive low levels wrong");
  AST_SR_IN: assert property (sre && !self_refresh_o |=> self_refresh_o && !dll_enable_o)
    else $error("dll not off in self refresh");
  AST_SR_OUT: assert property (self_refresh_o && cke_i |=> !self_refresh_o && dll_reset_o)
    else $error("no dll reset on self refresh exit");
endmodule : ddrmr_chk
bind ddrmr_top ddrmr_chk #(.DQ_W(DQ_W)) u_chk (
  .ref_clk_i, .rst_n_i, .cs_n_i, .ras_n_i, .cas_n_i, .we_n_i, .cke_i, .bank_select_i, .addr_i,
  .dq_o, .dq_oe_n_o, .dqs_o, .dqs_n_o, .dqs_oe_n_o, .burst_length_o, .burst_type_o,
  .read_latency_setting_o, .dll_reset_o, .write_recovery_o, .dll_enable_o, .additive_latency_o, .test_mode_o,
  .strobe_n_disable_o, .calibration_mode_o, .extended_refresh_rate_o, .reduced_drive_o, .termination_o, .self_refresh_o
);
`default_nettype wire

// file: ddrmr_ctrl_model.sv
// memory controller model: register writes, self refresh and adjust bursts
// assumes its tasks are called just after a rising edge of clk_i
`default_nettype none
module ddrmr_ctrl_model #(
  parameter int DQ_W = 16,
  parameter int TCMD = 2
) (
  input  wire logic            clk_i,
  output var  logic            cs_n_o,
  output var  logic            ras_n_o,
  output var  logic            cas_n_o,
  output var  logic            we_n_o,
  output var  logic            cke_o,
  output var  logic [1:0]      bank_o,
  output var  logic [12:0]     addr_o,
  output var  logic [DQ_W-1:0] dq_rise_o,
  output var  logic [DQ_W-1:0] dq_fall_o
);
  initial begin
    {cs_n_o, ras_n_o, cas_n_o, we_n_o, cke_o} = 5'h1F;
    bank_o = 2'h0;
    addr_o = 13'h0000;
    dq_rise_o = '0;
    dq_fall_o = '1;
  end
  // one command cycle, then deselect and spacing
  task automatic issue(input logic [3:0] s, input logic k, input logic [1:0] b, input logic [12:0] a);
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= s;
    cke_o  <= k;
    bank_o <= b;
    addr_o <= a;
    @(posedge clk_i);
    cs_n_o <= 1'b1;
    bank_o <= ~b;
    addr_o <= ~a;
    repeat (TCMD) @(posedge clk_i);
  endtask : issue
  // adjust command, then the four code beats to every data line
  task automatic adjust(input int wlat, input logic [12:0] a, input logic [3:0] c);
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= 4'h0;
    bank_o <= 2'h1;
    addr_o <= a;
    @(posedge clk_i);
    cs_n_o <= 1'b1;
    repeat (wlat - 1) @(posedge clk_i);
    dq_rise_o <= {DQ_W{c[3]}};
    dq_fall_o <= {DQ_W{c[2]}};
    @(posedge clk_i);
    dq_rise_o <= {DQ_W{c[1]}};
    dq_fall_o <= {DQ_W{c[0]}};
    @(posedge clk_i);
    dq_rise_o <= {DQ_W{~c[1]}};
    dq_fall_o <= {DQ_W{~c[0]}};
    @(posedge clk_i);
  endtask : adjust
endmodule : ddrmr_ctrl_model
`default_nettype wire

// file: ddrmr_top_tb.sv
// self-checking bench: controller model at the pins, AXI4-Lite master here
// assumes ddrmr_chk is bound into the design by its own file
`default_nettype none
module ddrmr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WLAT = 4; // additive 2 plus read 3 less one
  localparam logic [1:0] OK = ddrmr_pkg::RESP_OKAY;
  localparam logic [2:0] DRV [4] = '{3'h1, 3'h2, 3'h7, 3'h0};
  localparam logic [3:0] CODES [11] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'h6, 4'h9, 4'hA, 4'h0, 4'h3, 4'hF};
  logic        ref_clk_i, rst_n_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, cke_i, dq_oe_n_o, dqs_o, dqs_n_o;
  logic        dll_enable_o, self_refresh_o, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  bank_select_i, s_axi_bresp, s_axi_rresp;
  logic [12:0] addr_i, a;
  logic [15:0] dq_rise_i, dq_fall_i, dq_o;
  logic [2:0]  burst_length_o;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, st;
  logic [31:0] s_axi_wdata, s_axi_rdata, rng;
  logic [33:0] exp_q[$];
  int          failures, num_checks;
  ddrmr_top #(.DQ_W(16)) dut (
    .ref_clk_i, .rst_n_i, .cs_n_i, .ras_n_i, .cas_n_i, .we_n_i, .cke_i, .bank_select_i, .addr_i,
    .dq_rise_i, .dq_fall_i, .dq_o, .dq_oe_n_o, .dqs_o, .dqs_n_o, .dqs_oe_n_o(), .burst_length_o,
    .burst_type_o(), .read_latency_setting_o(), .test_mode_o(), .dll_reset_o(), .write_recovery_o(),
    .dll_enable_o, .reduced_drive_o(), .additive_latency_o(), .termination_o(), .strobe_n_disable_o(),
    .calibration_mode_o(), .extended_refresh_rate_o(), .pull_up_step_o(), .pull_down_step_o(),
    .self_refresh_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  ddrmr_ctrl_model #(.DQ_W(16)) ctl (
    .clk_i(ref_clk_i), .cs_n_o(cs_n_i), .ras_n_o(ras_n_i), .cas_n_o(cas_n_i), .we_n_o(we_n_i),
    .cke_o(cke_i), .bank_o(bank_select_i), .addr_o(addr_i), .dq_rise_o(dq_rise_i), .dq_fall_o(dq_fall_i)
  );
  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic tmo(input int n);
    if (n >= 64) begin
      failures++;
      finish_test();
    end
  endtask : tmo
  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr  <= ad;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 64);
    check(34'(s_axi_bresp), 34'(er));
    s_axi_bready <= 1'b0;
    tmo(n);
    @(posedge ref_clk_i);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] ad, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    exp_q.push_back({er, ed});
    s_axi_araddr  <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 64);
    s_axi_rready <= 1'b0;
    tmo(n);
    @(posedge ref_clk_i);
  endtask : axi_rd
  always @(posedge ref_clk_i) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // expected strengths after one adjust code, saturating at both ends
  function automatic logic [7:0] step(input logic [7:0] s, input logic [3:0] c);
    logic [3:0] u;
    logic [3:0] d;
    u = s[3:0];
    d = s[7:4];
    if (c inside {4'h1, 4'h5, 4'h9} && u != 4'hF) u = u + 4'h1;
    if (c inside {4'h2, 4'h6, 4'hA} && u != 4'h0) u = u - 4'h1;
    if (c inside {4'h4, 4'h5, 4'h6} && d != 4'hF) d = d + 4'h1;
    if (c inside {4'h8, 4'h9, 4'hA} && d != 4'h0) d = d - 4'h1;
    return {d, u};
  endfunction : step
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    {rst_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    failures = 0;
    num_checks = 0;
    rng = 32'h27;
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    axi_rd(ddrmr_pkg::OFS_STRENGTH, 32'h88, OK);
    axi_rd(ddrmr_pkg::OFS_STATUS, 32'h2, OK);
    axi_rd(8'h40, 32'h0, ddrmr_pkg::RESP_SLVERR);
    axi_wr(8'h40, rng, ddrmr_pkg::RESP_SLVERR);
    axi_wr(ddrmr_pkg::OFS_MODE, 32'h1FFF, OK);
    axi_rd(ddrmr_pkg::OFS_MODE, 32'h0, OK);
    ctl.issue(4'h0, 1'b1, 2'h2, 13'h0080);
    ctl.issue(4'h0, 1'b1, 2'h3, 13'h0000);
    ctl.issue(4'h0, 1'b1, 2'h1, 13'h0056);
    ctl.issue(4'h0, 1'b1, 2'h0, 13'h0132);
    repeat (200) @(posedge ref_clk_i);
    axi_rd(ddrmr_pkg::OFS_EXT2, 32'h80, OK);
    axi_rd(ddrmr_pkg::OFS_EXT3, 32'h0, OK);
    axi_rd(ddrmr_pkg::OFS_EXT1, 32'h56, OK);
    for (int i = 0; i < 6; i++) begin
      rng = xs(rng);
      a = {rng[12:8], 1'b0, rng[6:3], (i[0] ? ddrmr_pkg::LEN_CODE8 : ddrmr_pkg::LEN_CODE4)};
      ctl.issue(4'h0, 1'b1, 2'h0, a);
      check(34'(burst_length_o), 34'(a[2:0]));
      axi_rd(ddrmr_pkg::OFS_MODE, 32'(a), OK);
    end
    ctl.issue(4'h0, 1'b1, 2'h0, 13'h0032);
    foreach (DRV[i]) begin
      ctl.issue(4'h0, 1'b1, 2'h1, 13'h0010 | {3'h0, DRV[i], 7'h00});
      check(34'({dq_oe_n_o, dqs_o, dqs_n_o, dq_o}),
            34'(DRV[i] == 3'h1 ? 19'h2FFFF : DRV[i] == 3'h2 ? 19'h10000 : 19'h40000));
    end
    foreach (CODES[i]) begin
      st = i[0] ? 8'h0F : 8'hF0;
      axi_wr(ddrmr_pkg::OFS_STRENGTH, 32'(st), OK);
      ctl.adjust(WLAT, 13'h0200, CODES[i]);
      ctl.issue(4'h0, 1'b1, 2'h1, 13'h0010);
      axi_rd(ddrmr_pkg::OFS_STRENGTH, 32'(step(st, CODES[i])), OK);
    end
    ctl.issue(4'h1, 1'b0, 2'h0, 13'h0000);
    check(34'({self_refresh_o, dll_enable_o}), 34'h2);
    axi_rd(ddrmr_pkg::OFS_STATUS, 32'h1, OK);
    ctl.issue(4'hF, 1'b1, 2'h0, 13'h0000);
    check(34'({self_refresh_o, dll_enable_o}), 34'h1);
    axi_rd(ddrmr_pkg::OFS_STATUS, 32'h2, OK);
    finish_test();
  end
endmodule : ddrmr_top_tb
`default_nettype wire
